// >>> rtl/pimc_channel.v
// Purpose: pulse input measure channel with AHB-Lite register access
// Assumes: clock buses arrive as hclk-domain enable pulses
// Notes: time counters step by 256 per count clock
//
// Added by the designer: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "pimc_regs.vh"
module pimc_channel #(
  parameter TW = 32,
  parameter EW = 16
) (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  input wire [5:0] clock_bus,
  input wire measured_input,
  output reg capture_flag
);
  // ==========================================================
  // declarations
  reg [10:0] ctrl_q;
  reg [TW-1:0] time_counter;
  reg [EW-1:0] event_counter;
  reg [TW-1:0] second_time_counter;
  reg [TW-1:0] first_general_register;
  reg [EW-1:0] second_general_register;
  reg [TW-1:0] third_general_register;
  reg [TW-1:0] fourth_general_register;
  reg ematch_q;
  reg wr_pend_q;
  reg [7:0] wr_addr_q;
  wire in_level;
  wire in_rise;
  wire in_fall;
  wire enable;
  wire [1:0] mode;
  wire [2:0] bus_sel;
  wire [1:0] edge_sel;
  wire lvl_sel;
  wire tick;
  wire ev_edge;
  wire lvl_gate;
  wire tmatch;
  wire ematch;
  wire clr_flag;
  // ==========================================================
  // helper functions
  function [TW-1:0] step;
    input [TW-1:0] v;
    begin
      step = v + `PIMC_TCNT_STEP;
    end
  endfunction
  function edge_pick;
    input [1:0] sel;
    input r;
    input f;
    begin
      case (sel)
        `PIMC_EDGE_RISE: edge_pick = r;
        `PIMC_EDGE_FALL: edge_pick = f;
        `PIMC_EDGE_BOTH: edge_pick = r | f;
        default: edge_pick = 1'b0;
      endcase
    end
  endfunction
  // ==========================================================
  // input synchroniser
  pimc_edge_sync u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin_in(measured_input),
    .level(in_level),
    .rise(in_rise),
    .fall(in_fall)
  );
  // ==========================================================
  // control decode
  assign enable = ctrl_q[`PIMC_CTRL_EN];
  assign mode = ctrl_q[`PIMC_CTRL_MODE_MSB:`PIMC_CTRL_MODE_LSB];
  assign bus_sel = ctrl_q[`PIMC_CTRL_CLK_MSB:`PIMC_CTRL_CLK_LSB];
  assign edge_sel = ctrl_q[`PIMC_CTRL_EDGE_MSB:`PIMC_CTRL_EDGE_LSB];
  assign lvl_sel = ctrl_q[`PIMC_CTRL_LVL];
  // bus codes above five select no clock
  assign tick = enable && (bus_sel < `PIMC_NUM_BUS) && clock_bus[bus_sel];
  // level mode always counts falling edges; others use the edge select
  assign ev_edge = enable && ((mode == `PIMC_MODE_LVL) ? in_fall :
                   edge_pick(edge_sel, in_rise, in_fall));
  assign lvl_gate = (in_level == lvl_sel);
  assign tmatch = enable && (mode == `PIMC_MODE_EDGE) &&
                  (time_counter == first_general_register);
  assign ematch = enable && (mode != `PIMC_MODE_EDGE) &&
                  (event_counter == second_general_register);
  assign clr_flag = wr_pend_q && (wr_addr_q == `PIMC_OFS_STAT) && hwdata[0];
  // ==========================================================
  // time counter
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      time_counter <= {TW{1'b0}};
    end else begin
      // a bus write to the counter wins over counting; the event match acts on the next count clock
      if (wr_pend_q && wr_addr_q == `PIMC_OFS_TCNT) begin
        time_counter <= hwdata[TW-1:0];
      end else if (mode == `PIMC_MODE_EDGE) begin
        if (tmatch) begin
          time_counter <= {TW{1'b0}};
        end else if (tick) begin
          time_counter <= step(time_counter);
        end
      end else if (mode == `PIMC_MODE_IVAL) begin
        if (tick && ematch_q) begin
          time_counter <= `PIMC_TCNT_STEP;
        end else if (tick) begin
          time_counter <= step(time_counter);
        end
      end else begin
        // level and pwm: counts only at the chosen level
        if (tick && ematch_q) begin
          time_counter <= lvl_gate ? `PIMC_TCNT_STEP : {TW{1'b0}};
        end else if (tick && lvl_gate) begin
          time_counter <= step(time_counter);
        end
      end
    end
  end
  // ==========================================================
  // event counter
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      event_counter <= {EW{1'b0}};
    end else if (wr_pend_q && wr_addr_q == `PIMC_OFS_ECNT) begin
      event_counter <= hwdata[EW-1:0];
    end else if (tmatch || (ematch && !ematch_q)) begin
      // clear and simultaneous edge merge into one count
      event_counter <= ev_edge ? {{(EW-1){1'b0}}, 1'b1} : {EW{1'b0}};
    end else if (ev_edge) begin
      event_counter <= event_counter + {{(EW-1){1'b0}}, 1'b1};
    end
  end
  // ==========================================================
  // pending event match, held until the next count clock
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ematch_q <= 1'b0;
    end else if (!enable || mode == `PIMC_MODE_EDGE) begin
      ematch_q <= 1'b0;
    end else if (ematch && !ematch_q) begin
      ematch_q <= 1'b1;
    end else if (tick) begin
      ematch_q <= 1'b0;
    end
  end
  // ==========================================================
  // second time counter, ungated, pwm only
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      second_time_counter <= {TW{1'b0}};
    end else if (wr_pend_q && wr_addr_q == `PIMC_OFS_TCNT2) begin
      second_time_counter <= hwdata[TW-1:0];
    end else if (mode == `PIMC_MODE_PWM && tick) begin
      second_time_counter <= ematch_q ? `PIMC_TCNT_STEP : step(second_time_counter);
    end else if (mode != `PIMC_MODE_PWM) begin
      second_time_counter <= second_time_counter;
    end
  end
  // ==========================================================
  // general registers and capture flag
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      first_general_register <= {TW{1'b0}};
      second_general_register <= {EW{1'b0}};
      third_general_register <= {TW{1'b0}};
      fourth_general_register <= {TW{1'b0}};
      capture_flag <= 1'b0;
    end else begin
      if (wr_pend_q && wr_addr_q == `PIMC_OFS_GR1) begin
        first_general_register <= hwdata[TW-1:0];
      end else if (mode != `PIMC_MODE_EDGE && tick && ematch_q) begin
        first_general_register <= time_counter;
      end
      if (wr_pend_q && wr_addr_q == `PIMC_OFS_GR2) begin
        second_general_register <= hwdata[EW-1:0];
      end else if (tmatch) begin
        second_general_register <= event_counter;
      end
      if (wr_pend_q && wr_addr_q == `PIMC_OFS_GR3) begin
        third_general_register <= hwdata[TW-1:0];
      end else if (mode == `PIMC_MODE_PWM && tick && ematch_q) begin
        third_general_register <= second_time_counter;
      end
      // fourth register is plain storage in every mode
      if (wr_pend_q && wr_addr_q == `PIMC_OFS_GR4) begin
        fourth_general_register <= hwdata[TW-1:0];
      end
      // a capture in the same cycle as the clear wins
      if (tmatch || (mode != `PIMC_MODE_EDGE && tick && ematch_q)) begin
        capture_flag <= 1'b1;
      end else if (clr_flag) begin
        capture_flag <= 1'b0;
      end
    end
  end
  // ==========================================================
  // AHB-Lite slave: zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      ctrl_q <= `PIMC_CTRL_RST;
      hrdata <= 32'h00000000;
    end else begin
      wr_pend_q <= hsel && hready && htrans[1] && hwrite;
      if (hsel && hready && htrans[1]) begin
        wr_addr_q <= haddr[7:0];
      end
      if (wr_pend_q && wr_addr_q == `PIMC_OFS_CTRL) begin
        ctrl_q <= hwdata[10:0];
      end
      if (hsel && hready && htrans[1] && !hwrite) begin
        case (haddr[7:0])
          `PIMC_OFS_CTRL: hrdata <= {21'h000000, ctrl_q};
          `PIMC_OFS_STAT: hrdata <= {30'h00000000, in_level, capture_flag};
          `PIMC_OFS_TCNT: hrdata <= time_counter;
          `PIMC_OFS_ECNT: hrdata <= {{(32-EW){1'b0}}, event_counter};
          `PIMC_OFS_TCNT2: hrdata <= second_time_counter;
          `PIMC_OFS_GR1: hrdata <= first_general_register;
          `PIMC_OFS_GR2: hrdata <= {{(32-EW){1'b0}}, second_general_register};
          `PIMC_OFS_GR3: hrdata <= third_general_register;
          `PIMC_OFS_GR4: hrdata <= fourth_general_register;
          default: hrdata <= 32'h00000000;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// >>> rtl/pimc_edge_sync.v
// Purpose: two-stage synchroniser and edge detector for the measured input
// Assumes: input is asynchronous to hclk
// Notes: edges appear two cycles after the pin changes
`timescale 1ns/1ps
`default_nettype none
module pimc_edge_sync (
  input wire hclk,
  input wire hresetn,
  input wire pin_in,
  output wire level,
  output wire rise,
  output wire fall
);
  reg meta_q;
  reg sync_q;
  reg prev_q;
  // ==========================================================
  // synchroniser and history
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= pin_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end
  assign level = sync_q;
  assign rise = sync_q & ~prev_q;
  assign fall = ~sync_q & prev_q;
endmodule
`default_nettype wire

// >>> rtl/pimc_regs.vh
// Purpose: register map and constants of the pulse input measure channel
// Assumes: AHB-Lite slave, 32-bit word registers
// Notes: all offsets are byte addresses
`ifndef PIMC_REGS_VH
`define PIMC_REGS_VH
// ==========================================================
// register offsets
`define PIMC_OFS_CTRL 8'h00
`define PIMC_OFS_STAT 8'h04
`define PIMC_OFS_TCNT 8'h08
`define PIMC_OFS_ECNT 8'h0C
`define PIMC_OFS_TCNT2 8'h10
`define PIMC_OFS_GR1 8'h14
`define PIMC_OFS_GR2 8'h18
`define PIMC_OFS_GR3 8'h1C
`define PIMC_OFS_GR4 8'h20
// ==========================================================
// control fields
`define PIMC_CTRL_EN 0
`define PIMC_CTRL_MODE_LSB 1
`define PIMC_CTRL_MODE_MSB 2
`define PIMC_CTRL_CLK_LSB 4
`define PIMC_CTRL_CLK_MSB 6
`define PIMC_CTRL_EDGE_LSB 8
`define PIMC_CTRL_EDGE_MSB 9
`define PIMC_CTRL_LVL 10
// ==========================================================
// mode and edge codes
`define PIMC_MODE_EDGE 2'h0
`define PIMC_MODE_IVAL 2'h1
`define PIMC_MODE_LVL 2'h2
`define PIMC_MODE_PWM 2'h3
`define PIMC_EDGE_RISE 2'h1
`define PIMC_EDGE_FALL 2'h2
`define PIMC_EDGE_BOTH 2'h3
// ==========================================================
// reset values and constants
`define PIMC_CTRL_RST 11'h000
`define PIMC_TCNT_STEP 32'h00000100
`define PIMC_NUM_BUS 6
`endif

// >>> sim/pimc_channel_props.sv
// Purpose: port-level checks of the pulse input measure channel
// Assumes: zero-wait AHB-Lite slave, one clock domain
// Notes: shadows the control word from observed bus writes
`timescale 1ns/1ps
`default_nettype none
module pimc_channel_props (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [5:0] clock_bus,
  input wire logic measured_input,
  input wire logic capture_flag
);
  // ==========================================
  // data phase tracking
  logic [7:0] a_q;
  logic w_q;
  logic r_q;
  logic [10:0] ctrl_q;
  wire logic take = hsel && hready && htrans[1];
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      a_q <= 8'h00;
      w_q <= 1'b0;
      r_q <= 1'b0;
      ctrl_q <= 11'h000;
    end else begin
      a_q <= take ? haddr[7:0] : a_q;
      w_q <= take && hwrite;
      r_q <= take && !hwrite;
      ctrl_q <= (w_q && a_q == 8'h00) ? hwdata[10:0] : ctrl_q;
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  AST_READY_ONE: assert property (hreadyout) else $error("ready low");
  AST_RESP_OKAY: assert property (!hresp) else $error("resp not okay");
  AST_STAT_READ: assert property (r_q && a_q == 8'h04 |-> hrdata[0] == $past(capture_flag))
    else $error("stat flag wrong");
  AST_UNMAPPED_ZERO: assert property (r_q && a_q > 8'h20 |-> hrdata == 32'h00000000)
    else $error("unmapped read not zero");
  AST_CTRL_BACK: assert property (r_q && a_q == 8'h00 |-> hrdata == {21'h000000, $past(ctrl_q)})
    else $error("ctrl readback wrong");
  AST_FLAG_CLEAR: assert property ($fell(capture_flag) |-> $past(w_q && a_q == 8'h04 && hwdata[0]))
    else $error("flag fell without clear");
  AST_TICK_FLAG: assert property ($rose(capture_flag) && ctrl_q[2:1] != 2'h0 |-> $past(clock_bus[ctrl_q[6:4]]))
    else $error("flag not after tick");
  AST_EDGE_FLAG: assert property ($rose(capture_flag) && ctrl_q[2:1] == 2'h0 |-> $past(clock_bus[ctrl_q[6:4]], 2))
    else $error("edge flag not after match");
  AST_OFF_NO_FLAG: assert property ($rose(capture_flag) |-> $past(ctrl_q[0]))
    else $error("flag while disabled");
  AST_RDATA_HOLD: assert property (!$past(take && !hwrite) |-> $stable(hrdata))
    else $error("read data moved");
  COV_IVAL: cover property ($rose(capture_flag) && ctrl_q[2:1] == 2'h1);
  COV_PWM: cover property ($rose(capture_flag) && ctrl_q[2:1] == 2'h3);
  COV_CLEAR: cover property ($fell(capture_flag));
endmodule
bind pimc_channel pimc_channel_props u_pimc_channel_props (.*);
`default_nettype wire

// >>> sim/pimc_pwm_src.sv
// Purpose: pwm source driving the measured input
// Assumes: steps on hclk, idles low while run is low
// Notes: high phase comes first after run rises
`timescale 1ns/1ps
`default_nettype none
module pimc_pwm_src (
  input wire logic hclk,
  input wire logic run,
  input wire logic [7:0] hi_len,
  input wire logic [7:0] lo_len,
  output var logic measured_input
);
  // ==========================================
  // period counter
  logic [8:0] cnt_q = 9'h000;
  always @(posedge hclk) begin
    cnt_q <= (!run || cnt_q == hi_len + lo_len - 9'h001) ? 9'h000 : cnt_q + 9'h001;
  end
  assign measured_input = run && cnt_q < {1'b0, hi_len};
endmodule
`default_nettype wire

// >>> sim/pulse_input_measure_channel_bench.sv
// Purpose: self-checking bench of the pulse input measure channel
// Assumes: bench drives clock bus ticks by hand
// Notes: counter and capture expectations follow from tick and pulse counts
`timescale 1ns/1ps
`default_nettype none
`include "pimc_regs.vh"
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module pulse_input_measure_channel_bench;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic run = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [5:0] clock_bus = 6'h00;
  logic [7:0] hi_len = 8'h02;
  logic [7:0] lo_len = 8'h02;
  logic [31:0] rd;
  int n_mismatch = 0;
  int samples_checked = 0;
  wire logic hready;
  wire logic hresp;
  wire logic capture_flag;
  wire logic measured_input;
  wire logic [31:0] hrdata;
  pimc_channel u_pimc_channel (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready, .hrdata, .hreadyout(hready), .hresp, .clock_bus, .measured_input, .capture_flag);
  pimc_pwm_src u_pimc_pwm_src (.hclk, .run, .hi_len, .lo_len, .measured_input);
  always #12.5 hclk = ~hclk;
  // ==========================================
  // access tasks
  task automatic wrap_up;
    if (n_mismatch == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wt;
    int n;
    n = 0;
    do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 40);
    if (hready !== 1'b1) begin n_mismatch++; wrap_up; end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h000000, a};
    wt;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wt;
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d); bus(1'b1, a, d); endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK($sformatf("reg %h", a), e, rd)
  endtask
  task automatic tick(input int b);
    clock_bus <= 6'h01 << b;
    @(posedge hclk);
    clock_bus <= 6'h00;
    @(posedge hclk);
  endtask
  task automatic go(input logic [7:0] h, input logic [7:0] l); hi_len <= h; lo_len <= l; run <= 1'b1; endtask
  task automatic pwm(input int n); go(8'h02, 8'h02); repeat (n) @(posedge hclk); run <= 1'b0;
    repeat (4) @(posedge hclk); endtask
  task automatic wf;
    int n;
    n = 0;
    while (capture_flag !== 1'b1 && n < 100) begin @(posedge hclk); n++; end
    `CHK("flag", 1'b1, capture_flag)
    if (capture_flag !== 1'b1) wrap_up;
  endtask
  function automatic logic [31:0] ct(input logic [1:0] m, input logic [2:0] c, input logic [1:0] e, input logic l);
    return {21'h000000, l, e, 1'b0, c, 1'b0, m, 1'b1};
  endfunction
  // ==========================================
  // scenarios
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    for (int a = 0; a < 40; a += 4) rc(a[7:0], 32'h0);
    wr(8'h24, 32'hFFFFFFFF);
    rc(8'h24, 32'h0);
    wr(8'h14, 32'hFFFFFF00);
    for (int e = 1; e < 4; e++) begin
      wr(8'h0C, 32'h0);
      wr(8'h00, ct(`PIMC_MODE_EDGE, 3'h0, e[1:0], 1'b0));
      rc(8'h00, ct(`PIMC_MODE_EDGE, 3'h0, e[1:0], 1'b0));
      pwm(12);
      rc(8'h0C, e == 3 ? 32'h6 : 32'h3);
    end
    wr(8'h00, 32'h0);
    pwm(12);
    rc(8'h0C, 32'h6);
    wr(8'h14, 32'h300);
    wr(8'h08, 32'h0);
    wr(8'h0C, 32'h0);
    wr(8'h00, ct(`PIMC_MODE_EDGE, 3'h2, `PIMC_EDGE_FALL, 1'b0));
    pwm(8);
    tick(1);
    rc(8'h08, 32'h0);
    tick(2);
    tick(2);
    pwm(4);
    tick(2);
    wf;
    rc(8'h18, 32'h3);
    rc(8'h0C, 32'h0);
    rc(8'h08, 32'h0);
    wr(8'h04, 32'h1);
    rc(8'h04, 32'h0);
    repeat (3) tick(2);
    wf;
    rc(8'h18, 32'h0);
    wr(8'h04, 32'h1);
    wr(8'h08, 32'h0);
    wr(8'h18, 32'h2);
    wr(8'h00, ct(`PIMC_MODE_IVAL, 3'h3, `PIMC_EDGE_FALL, 1'b0));
    tick(3);
    tick(3);
    pwm(8);
    rc(8'h0C, 32'h0);
    `CHK("flag", 1'b0, capture_flag)
    tick(3);
    wf;
    rc(8'h14, 32'h200);
    rc(8'h08, 32'h100);
    rc(8'h10, 32'h0);
    rc(8'h1C, 32'h0);
    wr(8'h04, 32'h1);
    wr(8'h08, 32'h0);
    wr(8'h18, 32'h1);
    wr(8'h00, ct(`PIMC_MODE_LVL, 3'h4, 2'h0, 1'b1));
    tick(4);
    rc(8'h08, 32'h0);
    go(8'd30, 8'd40);
    repeat (3) @(posedge hclk);
    tick(4);
    tick(4);
    repeat (30) @(posedge hclk);
    tick(4);
    wf;
    run <= 1'b0;
    rc(8'h14, 32'h200);
    rc(8'h08, 32'h0);
    wr(8'h04, 32'h1);
    wr(8'h08, 32'h0);
    wr(8'h10, 32'h0);
    wr(8'h0C, 32'h0);
    wr(8'h18, 32'h2);
    wr(8'h00, ct(`PIMC_MODE_PWM, 3'h5, `PIMC_EDGE_RISE, 1'b0));
    tick(5);
    go(8'd10, 8'd30);
    repeat (5) @(posedge hclk);
    tick(5);
    repeat (8) @(posedge hclk);
    tick(5);
    tick(5);
    repeat (25) @(posedge hclk);
    tick(5);
    wf;
    run <= 1'b0;
    rc(8'h14, 32'h300);
    rc(8'h1C, 32'h400);
    rc(8'h08, 32'h0);
    rc(8'h10, 32'h100);
    rc(8'h20, 32'h0);
    wrap_up;
  end
endmodule
`default_nettype wire
